// ==== inc/test_pattern_map.svh ====
/*
  Offsets, field positions, reset values and counts of the test pattern control block.
  Assumes it is included by bare name and only holds definitions.
*/
`ifndef TEST_PATTERN_MAP_SVH
`define TEST_PATTERN_MAP_SVH

// ****************************************************************
// Direct register offsets and reset values
// ****************************************************************
`define PG_CONFIG_OFS        8'h65
`define PG_IND_ADDR_OFS      8'h66
`define PG_IND_DATA_OFS      8'h67
`define PG_CONFIG_RST        8'h00
`define PG_IND_ADDR_RST      8'h00
`define PG_IND_DATA_RST      8'h00
`define PG_CONFIG_MASK       8'h7F

// ****************************************************************
// Configuration field positions
// ****************************************************************
`define PG_AUTO_SCROLL_BIT   0
`define PG_SPARE_BIT         1
`define PG_TIMING_SEL_BIT    2
`define PG_EXT_CLK_BIT       3

// ****************************************************************
// Indirect register offsets (totals and actives are 12-bit: low byte, then high nibble; the rest are single bytes)
// ****************************************************************
`define PG_I_FRAME_TIME      4'h0
`define PG_I_HTOTAL          4'h1
`define PG_I_VTOTAL          4'h3
`define PG_I_HACTIVE         4'h5
`define PG_I_VACTIVE         4'h7
`define PG_I_HSYNC_W         4'h9
`define PG_I_VSYNC_W         4'hA
`define PG_I_HBP             4'hB
`define PG_I_VBP             4'hC
`define PG_I_SYNC_CFG        4'hD
`define PG_I_PAT_ENABLE      4'hE

// ****************************************************************
// Timing counts
// ****************************************************************
`define PG_CLK_DIV           4
`define PG_RD_LATENCY        2

`endif

// ==== inc/test_pattern_pkg.sv ====
/*
  Types shared by the test pattern control design files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package test_pattern_pkg;

  // ****************************************************************
  // Shared types
  // ****************************************************************
  typedef logic [7:0] byte_t;
  typedef logic [11:0] span_t;
  typedef enum logic {
    ext_timing,
    int_timing
  } timing_mode_e;

endpackage : test_pattern_pkg

// ==== rtl/pattern_ind_mem.sv ====
/*
  Memory behind the indirect address/data port of the pattern generator.
  Assumes one access per cycle; read data come out of a register one cycle later.
*/
module pattern_ind_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] q
);

  logic [DW-1:0]        mem [0:(1<<AW)-1];
  logic [(1<<AW)-1:0]   written;

  // Write port; the array itself has no reset.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // One flag a word, so that a word never written reads as zero, not unknown.
  always_ff @(posedge mclk) begin
    if (reset) begin
      written <= '0;
    end else if (we) begin
      written[addr] <= 1'b1;
    end
  end

  // Registered read of the addressed word.
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= written[addr] ? mem[addr] : '0;
    end
  end

endmodule : pattern_ind_mem

// ==== rtl/test_pattern_control.sv ====
/*
  Control of the internal video test pattern generator: configuration and
  indirect registers, external or internal video timing, and auto-scroll.
  Assumes a byte-wide register port from the serial control bus and video
  inputs that are asynchronous and slower than a quarter of mclk.
*/
`include "test_pattern_map.svh"
module test_pattern_control #(
  parameter int CLK_DIV = `PG_CLK_DIV
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rdata_valid,
  input  wire logic       ext_pclk,
  input  wire logic       ext_de,
  input  wire logic       ext_hs,
  input  wire logic       ext_vs,
  output logic            pg_de,
  output logic            pg_hs,
  output logic            pg_vs,
  output logic            pg_pixel_tick,
  output logic      [2:0] pattern_index,
  output logic      [7:0] pattern_config,
  output logic      [7:0] indirect_data
);

  // ****************************************************************
  // Register storage and bus decode
  // ****************************************************************
  test_pattern_pkg::byte_t       ind_addr;
  test_pattern_pkg::byte_t       mem_q;
  test_pattern_pkg::byte_t       shadow [0:15];
  test_pattern_pkg::timing_mode_e mode;
  logic [7:0] rd_addr_p1;
  logic       rd_p1;

  // Strobes for each mapped register.
  wire cfg_wr   = reg_wr && (reg_addr == `PG_CONFIG_OFS);
  wire ia_wr    = reg_wr && (reg_addr == `PG_IND_ADDR_OFS);
  wire id_wr    = reg_wr && (reg_addr == `PG_IND_DATA_OFS);
  wire sh_wr    = id_wr && (ind_addr[7:4] == 4'h0);
  wire tsel     = pattern_config[`PG_TIMING_SEL_BIT];
  wire auto_on  = pattern_config[`PG_AUTO_SCROLL_BIT];
  wire ext_clk  = pattern_config[`PG_EXT_CLK_BIT];

  // Configuration and indirect address registers; bit 1 is stored only.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pattern_config <= `PG_CONFIG_RST;
      ind_addr       <= `PG_IND_ADDR_RST;
    end else begin
      if (cfg_wr) pattern_config <= reg_wdata & `PG_CONFIG_MASK;
      if (ia_wr) ind_addr <= reg_wdata;
    end
  end

  // Indirect words go to memory at the current indirect address.
  pattern_ind_mem #(.AW(8), .DW(8)) u_mem (
    .mclk  (mclk),
    .reset (reset),
    .we    (id_wr),
    .addr  (ind_addr),
    .wdata (reg_wdata),
    .q     (mem_q)
  );

  // Copies of the low indirect words that the timing and auto-scroll logic read.
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) shadow[i] <= 8'h00;
    end else if (sh_wr) begin
      shadow[ind_addr[3:0]] <= reg_wdata;
    end
  end

  // Read data selected one cycle after the request, valid the cycle after.
  wire [7:0] rd_value = (rd_addr_p1 == `PG_CONFIG_OFS)   ? pattern_config :
                        (rd_addr_p1 == `PG_IND_ADDR_OFS) ? ind_addr :
                        (rd_addr_p1 == `PG_IND_DATA_OFS) ? mem_q : 8'h00;
  wire       id_rd_p1 = rd_p1 && (rd_addr_p1 == `PG_IND_DATA_OFS);

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_p1           <= 1'b0;
      rd_addr_p1      <= 8'h00;
      reg_rdata       <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      rd_p1           <= reg_rd && !reg_wr;
      rd_addr_p1      <= reg_addr;
      reg_rdata_valid <= rd_p1;
      if (rd_p1) reg_rdata <= rd_value;
    end
  end

  // Data register keeps the last word written or read back.
  always_ff @(posedge mclk) begin
    if (reset) begin
      indirect_data <= `PG_IND_DATA_RST;
    end else if (id_wr) begin
      indirect_data <= reg_wdata;
    end else if (id_rd_p1) begin
      indirect_data <= mem_q;
    end
  end

  // ****************************************************************
  // Input synchronisers and pixel tick
  // ****************************************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       pclk_s3;
  logic       vs_s3;
  logic [7:0] div_cnt;

  // Two stages before any logic looks at the video pins.
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1   <= 4'h0;
      sync2   <= 4'h0;
      pclk_s3 <= 1'b0;
      vs_s3   <= 1'b0;
    end else begin
      sync1   <= {ext_vs, ext_hs, ext_de, ext_pclk};
      sync2   <= sync1;
      pclk_s3 <= sync2[0];
      vs_s3   <= sync2[3];
    end
  end

  // Divider for the internal pixel rate.
  wire div_tick = (div_cnt == 8'(CLK_DIV - 1));
  always_ff @(posedge mclk) begin
    if (reset) div_cnt <= 8'h00;
    else div_cnt <= div_tick ? 8'h00 : div_cnt + 8'h01;
  end

  wire pclk_rise = sync2[0] && !pclk_s3;
  wire vs_rise   = sync2[3] && !vs_s3;
  wire pix_tick  = ext_clk ? pclk_rise : div_tick;
  assign pg_pixel_tick = tsel ? pix_tick : pclk_rise;
  assign mode = tsel ? test_pattern_pkg::int_timing : test_pattern_pkg::ext_timing;

  // ****************************************************************
  // Internal timing
  // ****************************************************************
  // Joins a low byte and the high nibble of the next word.
  function automatic test_pattern_pkg::span_t span(input logic [7:0] lo, input logic [7:0] hi);
    span = {hi[3:0], lo};
  endfunction : span

  // True while pos lies in the sync pulse placed just before the back porch.
  function automatic logic in_sync(input test_pattern_pkg::span_t pos,
                                   input test_pattern_pkg::span_t total,
                                   input logic [7:0] width,
                                   input logic [7:0] porch);
    logic [12:0] stop;
    logic [12:0] start;
    stop    = {1'b0, total} - {5'h00, porch};
    start   = stop - {5'h00, width};
    in_sync = ({1'b0, pos} >= start) && ({1'b0, pos} < stop);
  endfunction : in_sync

  test_pattern_pkg::span_t hcnt;
  test_pattern_pkg::span_t vcnt;
  wire test_pattern_pkg::span_t htotal  = span(shadow[`PG_I_HTOTAL], shadow[`PG_I_HTOTAL+1]);
  wire test_pattern_pkg::span_t vtotal  = span(shadow[`PG_I_VTOTAL], shadow[`PG_I_VTOTAL+1]);
  wire test_pattern_pkg::span_t hactive = span(shadow[`PG_I_HACTIVE], shadow[`PG_I_HACTIVE+1]);
  wire test_pattern_pkg::span_t vactive = span(shadow[`PG_I_VACTIVE], shadow[`PG_I_VACTIVE+1]);
  wire [7:0] sync_cfg = shadow[`PG_I_SYNC_CFG];
  wire       h_last   = ({1'b0, hcnt} + 13'h0001) >= {1'b0, htotal};
  wire       v_last   = ({1'b0, vcnt} + 13'h0001) >= {1'b0, vtotal};
  wire       int_de   = (hcnt < hactive) && (vcnt < vactive);
  wire       int_hs   = in_sync(hcnt, htotal, shadow[`PG_I_HSYNC_W], shadow[`PG_I_HBP])
                        ^ sync_cfg[0];
  wire       int_vs   = in_sync(vcnt, vtotal, shadow[`PG_I_VSYNC_W], shadow[`PG_I_VBP])
                        ^ sync_cfg[1];

  // Raster counters advance on the selected pixel tick.
  always_ff @(posedge mclk) begin
    if (reset || !tsel) begin
      hcnt <= 12'h000;
      vcnt <= 12'h000;
    end else if (pix_tick) begin
      hcnt <= h_last ? 12'h000 : hcnt + 12'h001;
      if (h_last) vcnt <= v_last ? 12'h000 : vcnt + 12'h001;
    end
  end

  // Video timing output: internal counters or synchronised pins.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pg_de <= 1'b0;
      pg_hs <= 1'b0;
      pg_vs <= 1'b0;
    end else if (mode == test_pattern_pkg::int_timing) begin
      pg_de <= int_de;
      pg_hs <= int_hs;
      pg_vs <= int_vs;
    end else begin
      pg_de <= sync2[1];
      pg_hs <= sync2[2];
      pg_vs <= sync2[3];
    end
  end

  // ****************************************************************
  // Auto-scroll
  // ****************************************************************
  // Next set bit of the enable mask after cur, wrapping; cur if none.
  function automatic logic [2:0] next_pattern(input logic [7:0] mask, input logic [2:0] cur);
    logic [2:0] idx;
    next_pattern = cur;
    for (int k = 7; k >= 1; k--) begin
      idx = 3'(cur + 3'(k));
      if (mask[idx]) next_pattern = idx;
    end
  endfunction : next_pattern

  logic [7:0] frame_cnt;
  wire frame_tick = tsel ? (pix_tick && h_last && v_last) : vs_rise;
  wire frame_done = frame_tick && ((frame_cnt + 8'h01) >= shadow[`PG_I_FRAME_TIME]);
  wire [2:0] next_pat = next_pattern(shadow[`PG_I_PAT_ENABLE], pattern_index);

  // Frames are counted only while scrolling; the pattern holds otherwise.
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_cnt     <= 8'h00;
      pattern_index <= 3'h0;
    end else if (!auto_on) begin
      frame_cnt <= 8'h00;
    end else if (frame_done) begin
      frame_cnt     <= 8'h00;
      pattern_index <= next_pat;
    end else if (frame_tick) begin
      frame_cnt <= frame_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  ext_follow_a: assert property (!tsel && $past(!tsel) |-> pg_de == $past(sync2[1]))
    else $error("external data enable not followed");
  int_timing_a: assert property (tsel && $past(tsel) |-> pg_de == $past(int_de))
    else $error("internal data enable not used");
  hold_pat_a: assert property (!auto_on |=> $stable(pattern_index))
    else $error("pattern changed without auto-scroll");
  scroll_step_a: assert property (auto_on && frame_done |=>
    pattern_index == $past(next_pat))
    else $error("auto-scroll step missed");
  iaddr_write_a: assert property (ia_wr |=> ind_addr == $past(reg_wdata)
    ##1 ($stable(ind_addr) || $past(ia_wr)))
    else $error("indirect address not loaded");
  idata_write_a: assert property (id_wr && ind_addr[7:4] == 4'h0 |=>
    shadow[$past(ind_addr[3:0])] == $past(reg_wdata))
    else $error("indirect write lost");
  idata_read_a: assert property (reg_rd && !reg_wr && reg_addr == `PG_IND_DATA_OFS |=>
    ##1 reg_rdata_valid && reg_rdata == $past(mem_q))
    else $error("indirect read data wrong");
  clk_select_a: assert property (tsel && !ext_clk |-> pg_pixel_tick == div_tick)
    else $error("divided clock not selected");
  spare_bit_a: assert property (cfg_wr |=>
    pattern_config[`PG_SPARE_BIT] == $past(reg_wdata[1]))
    else $error("config bit 1 not stored");

  scroll_c:   cover property (auto_on && frame_done ##1 pattern_index != $past(pattern_index));
  int_mode_c: cover property (tsel && pg_de ##1 !pg_de);
  rd_back_c:  cover property (id_wr ##1 reg_rd && reg_addr == `PG_IND_DATA_OFS
                              ##2 reg_rdata_valid);

endmodule : test_pattern_control

// ==== sim/test_pattern_control_tb_top.sv ====
/*
  Self-checking testbench of the test pattern control block: register port,
  indirect port, external and internal timing, and auto-scroll.
  Assumes the package, the map header and the design files are compiled first.
*/
`include "test_pattern_map.svh"
module test_pattern_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  localparam int DIV = 2;
  localparam logic [15:0] TBL [15] = '{16'h0002, 16'h0114, 16'h0200, 16'h030A, 16'h0400,
    16'h050C, 16'h0600, 16'h0706, 16'h0800, 16'h0902, 16'h0A01, 16'h0B02, 16'h0C01,
    16'h0D00, 16'h0E05};
  logic       mclk      = 1'b0;
  logic       reset     = 1'b1;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic       reg_rdata_valid;
  logic       ext_pclk  = 1'b0;
  logic       ext_de    = 1'b0;
  logic       ext_hs    = 1'b0;
  logic       ext_vs    = 1'b0;
  logic       pg_de;
  logic       pg_hs;
  logic       pg_vs;
  logic       pg_pixel_tick;
  logic [2:0] pattern_index;
  logic [7:0] pattern_config;
  logic [7:0] indirect_data;
  logic       pclk_run  = 1'b0;
  int         pclk_cnt  = 0;
  int         tick_cnt  = 0;
  int         err_total = 0;
  int         checked   = 0;
  int         gap;
  int         de_cyc;
  int         hs_cyc;
  logic [2:0] old_idx;

  test_pattern_control #(.CLK_DIV(DIV)) i_test_pattern_control (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .ext_pclk(ext_pclk), .ext_de(ext_de),
    .ext_hs(ext_hs), .ext_vs(ext_vs), .pg_de(pg_de), .pg_hs(pg_hs), .pg_vs(pg_vs),
    .pg_pixel_tick(pg_pixel_tick), .pattern_index(pattern_index),
    .pattern_config(pattern_config), .indirect_data(indirect_data));

  // The clock toggles every half period of 4 ns.
  always #4 mclk = ~mclk;

  // The pixel clock runs at an eighth of mclk, below the supported limit of a quarter.
  always @(negedge mclk) begin
    pclk_cnt <= (pclk_cnt + 1) % 4;
    if (pclk_run && pclk_cnt == 3) begin
      ext_pclk <= ~ext_pclk;
    end
  end

  // Pixel ticks are counted at the falling edge, where the pulse has settled.
  always @(negedge mclk) begin
    if (pg_pixel_tick === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Counts the run and reports a mismatch at once.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // One write strobe of one cycle, launched at a falling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  // One read strobe; the answer must be sampled exactly two edges after it is taken.
  // A value seen at a falling edge is the one that the next rising edge samples.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    int k;
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    k = 1;
    while (reg_rdata_valid !== 1'b1 && k < 8) begin
      @(negedge mclk);
      k++;
    end
    chk({nm, "_latency"}, 16'h0002, 16'(k));
    chk(nm, {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd

  // Waits for a rise of pg_vs, counting cycles, data-enable and hsync cycles on the way.
  // Called just after a rise, it spans one whole frame, high part of pg_vs included.
  task automatic vs_rise(output int cyc, output int de_n, output int hs_n);
    cyc = 0;
    de_n = 0;
    hs_n = 0;
    while (pg_vs !== 1'b0 && cyc < 5000) begin
      @(posedge mclk);
      #1;
      cyc++;
      de_n += (pg_de === 1'b1);
      hs_n += (pg_hs === 1'b1);
    end
    while (pg_vs !== 1'b1 && cyc < 10000) begin
      @(posedge mclk);
      #1;
      cyc++;
      de_n += (pg_de === 1'b1);
      hs_n += (pg_hs === 1'b1);
    end
  endtask : vs_rise

  // Waits for the pattern number to move, bounded.
  task automatic idx_change(output int cyc);
    logic [2:0] was_idx;
    was_idx = pattern_index;
    cyc = 0;
    while (pattern_index === was_idx && cyc < 5000) begin
      @(posedge mclk);
      #1;
      cyc++;
    end
  endtask : idx_change

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  // Watchdog reckoned at several times the expected length of the tests.
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  // Register, indirect port, timing and auto-scroll scenarios in turn.
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    rd(`PG_IND_ADDR_OFS, 8'h00, "ind_addr_reset");
    rd(`PG_IND_DATA_OFS, 8'h00, "ind_data_reset");
    rd(`PG_CONFIG_OFS, 8'h00, "config_reset");
    wr(`PG_IND_ADDR_OFS, 8'hA5);
    rd(`PG_IND_ADDR_OFS, 8'hA5, "ind_addr_rw");
    rd(8'h10, 8'h00, "unmapped_read");
    for (int i = 0; i < 15; i++) begin
      wr(`PG_IND_ADDR_OFS, TBL[i][15:8]);
      wr(`PG_IND_DATA_OFS, TBL[i][7:0]);
    end
    for (int i = 14; i >= 0; i -= 7) begin
      wr(`PG_IND_ADDR_OFS, TBL[i][15:8]);
      rd(`PG_IND_DATA_OFS, TBL[i][7:0], "ind_readback");
      chk("indirect_data", {8'h00, TBL[i][7:0]}, {8'h00, indirect_data});
    end
    wr(`PG_CONFIG_OFS, 8'hFF);
    rd(`PG_CONFIG_OFS, 8'h7F, "config_top_bit");
    chk("config_port", 16'h007F, {8'h00, pattern_config});
    wr(`PG_CONFIG_OFS, 8'h02);
    rd(`PG_CONFIG_OFS, 8'h02, "config_spare_bit");
    pclk_run = 1'b1;
    for (int p = 0; p < 2; p++) begin
      @(negedge mclk);
      {ext_de, ext_hs, ext_vs} = p ? 3'b010 : 3'b101;
      repeat (6) @(posedge mclk);
      #1;
      chk("external_timing", 16'({~p[0], p[0], ~p[0]}), 16'({pg_de, pg_hs, pg_vs}));
    end
    tick_cnt = 0;
    repeat (800) @(posedge mclk);
    #1;
    chk("pixel_ticks_ok", 16'h0001, 16'(tick_cnt >= 99 && tick_cnt <= 101));
    wr(`PG_CONFIG_OFS, 8'h04);
    vs_rise(gap, de_cyc, hs_cyc);
    vs_rise(gap, de_cyc, hs_cyc);
    chk("int_frame_cycles", 16'(20 * 10 * DIV), 16'(gap));
    chk("int_active_cycles", 16'(12 * 6 * DIV), 16'(de_cyc));
    chk("int_hsync_cycles", 16'(2 * 10 * DIV), 16'(hs_cyc));
    wr(`PG_IND_ADDR_OFS, 8'h0D);
    wr(`PG_IND_DATA_OFS, 8'h01);
    vs_rise(gap, de_cyc, hs_cyc);
    vs_rise(gap, de_cyc, hs_cyc);
    chk("inv_hsync_cycles", 16'((20 - 2) * 10 * DIV), 16'(hs_cyc));
    wr(`PG_CONFIG_OFS, 8'h0C);
    vs_rise(gap, de_cyc, hs_cyc);
    vs_rise(gap, de_cyc, hs_cyc);
    chk("pclk_frame_cycles", 16'(20 * 10 * 8), 16'(gap));
    chk("pclk_active_cycles", 16'(12 * 6 * 8), 16'(de_cyc));
    wr(`PG_CONFIG_OFS, 8'h05);
    idx_change(gap);
    chk("scroll_first_step", 16'h0002, {13'h0000, pattern_index});
    idx_change(gap);
    chk("scroll_wrap_step", 16'h0000, {13'h0000, pattern_index});
    chk("scroll_interval", 16'(2 * 20 * 10 * DIV), 16'(gap));
    wr(`PG_CONFIG_OFS, 8'h04);
    old_idx = pattern_index;
    repeat (2000) @(posedge mclk);
    #1;
    chk("scroll_off_holds", {13'h0000, old_idx}, {13'h0000, pattern_index});
    complete_run();
  end

endmodule : test_pattern_control_tb_top
